// >>> ecap_pkg.sv
/*
  Package for the capture/compare/PWM mode control block: register
  offsets, reset values, mode and steering encodings, carrier types and
  mode decode functions. Assumes an 8-bit register port and one clock.
*/
package ecap_pkg;

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 3;

  localparam logic [2:0] CTRL_ADDR       = 3'h0;
  localparam logic [2:0] CAP_LOW_ADDR    = 3'h1;
  localparam logic [2:0] CAP_HIGH_ADDR   = 3'h2;
  localparam logic [2:0] IRQ_FLAGS_ADDR  = 3'h3;
  localparam logic [2:0] IRQ_ENABLE_ADDR = 3'h4;

  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [15:0] CAP_RESET    = 16'h0000;
  localparam logic        FLAG_RESET   = 1'b0;
  localparam logic        ENABLE_RESET = 1'b0;
  localparam logic [7:0]  READ_ZERO    = 8'h00;

  // Position of the module bit in the shared flag and enable registers
  localparam int unsigned MODULE_IRQ_BIT = 5;

  // ---------------------------------------------------------------
  // Mode select encodings
  // ---------------------------------------------------------------
  localparam logic [3:0] MODE_OFF         = 4'h0;
  localparam logic [3:0] MODE_CMP_TOGGLE  = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL    = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE    = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4   = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16  = 4'h7;
  localparam logic [3:0] MODE_CMP_SET     = 4'h8;
  localparam logic [3:0] MODE_CMP_CLEAR   = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT    = 4'ha;
  localparam logic [3:0] MODE_CMP_SPECIAL = 4'hb;
  localparam logic [1:0] MODE_GROUP_PWM   = 2'h3;
  localparam logic [1:0] MODE_GROUP_CAP   = 2'h1;

  localparam logic [1:0] STEER_SINGLE = 2'h0;
  localparam logic [1:0] STEER_FWD    = 2'h1;
  localparam logic [1:0] STEER_HALF   = 2'h2;
  localparam logic [1:0] STEER_REV    = 2'h3;

  localparam int unsigned PRESC_W = 4;
  localparam logic [3:0]  PRESC_ZERO = 4'h0;
  localparam logic [3:0]  PRESC_ONE  = 4'h1;
  localparam logic [1:0]  PRESC_LAST4  = 2'h3;
  localparam logic [3:0]  PRESC_LAST16 = 4'hf;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] steer;
    logic [1:0] duty;
    logic [3:0] mode;
  } control_t;

  // Index 0 is output A (the capture/compare pin) up to 3 for output D
  typedef struct packed {
    logic [3:0] level;
    logic [3:0] drive_n;
  } pin_drive_t;

  localparam pin_drive_t PINS_IDLE = '{level: 4'h0, drive_n: 4'hf};

  typedef enum logic [1:0] {
    SE_IDLE = 2'b00,
    SE_WAIT = 2'b01
  } special_state_t;

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  function automatic logic is_capture(input logic [3:0] mode);
    return mode[3:2] == MODE_GROUP_CAP;
  endfunction

  function automatic logic is_pwm(input logic [3:0] mode);
    return mode[3:2] == MODE_GROUP_PWM;
  endfunction

  function automatic logic is_compare(input logic [3:0] mode);
    return mode == MODE_CMP_TOGGLE || mode[3:2] == 2'h2;
  endfunction

  // Compare modes that take over the capture/compare pin
  function automatic logic drives_pin(input logic [3:0] mode);
    return mode == MODE_CMP_TOGGLE || mode == MODE_CMP_SET ||
           mode == MODE_CMP_CLEAR;
  endfunction

endpackage

// >>> capture_prescaler.sv
/*
  Capture edge prescaler: turns synchronised pin edges into capture
  events for the four capture modes. Assumes edge pulses on clock_i.
*/
`timescale 1ns/1ps

module capture_prescaler
  import ecap_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  input  wire logic       ce_i,
  input  wire logic [3:0] mode_i,
  input  wire logic       rise_i,
  input  wire logic       fall_i,
  output logic            fire_o
);

  logic [PRESC_W-1:0] count_r;
  logic [PRESC_W-1:0] count_nxt;

  // Only the mode group clears the count, so switching between capture
  // settings keeps it and may fire early.
  assign count_nxt = !is_capture(mode_i) ? PRESC_ZERO :
                     rise_i ? count_r + PRESC_ONE : count_r;

  assign fire_o = (mode_i == MODE_CAP_FALL)   ? fall_i :
                  (mode_i == MODE_CAP_RISE)   ? rise_i :
                  (mode_i == MODE_CAP_RISE4)  ?
                    rise_i && count_r[1:0] == PRESC_LAST4 :
                  (mode_i == MODE_CAP_RISE16) ?
                    rise_i && count_r == PRESC_LAST16 : 1'b0;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_r <= PRESC_ZERO;
    end else if (ce_i) begin
      count_r <= count_nxt;
    end
  end

  a_presc_clear: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    ce_i && !is_capture(mode_i) |=> count_r == PRESC_ZERO)
    else $error("prescaler count not cleared outside capture");

endmodule // capture_prescaler

// >>> enhanced_capture_unit.sv
/*
  Mode control and capture part of a capture/compare/PWM unit: control,
  capture pair and interrupt flag registers, capture path, compare pin
  latch, special event trigger and PWM output steering. Assumes the
  timer one count, its tick and the PWM waveform come from logic on
  clock_i; only the capture pin is asynchronous.
*/
`timescale 1ns/1ps

module enhanced_capture_unit
  import ecap_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              reset_n_i,
  input  wire logic              ce_i,
  input  wire logic [2:0]        addr_i,
  input  wire logic [7:0]        wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [7:0]        rdata_o,
  input  wire logic              capture_pin_i,
  input  wire logic [15:0]       timer_one_count_i,
  input  wire logic              timer_one_tick_i,
  input  wire logic              adc_enabled_i,
  input  wire logic              pwm_primary_i,
  input  wire logic              pwm_complement_i,
  output ecap_pkg::pin_drive_t   pins_o,
  output logic      [9:0]        duty_value_o,
  output logic                   timer_two_base_o,
  output logic                   module_irq_flag_o,
  output logic                   module_irq_enable_o,
  output logic                   special_event_o,
  output logic                   adc_start_o,
  output logic                   timer_one_reset_o
);

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  control_t       ctrl_r;
  logic [15:0]    cap_r;
  logic [15:0]    cap_nxt;
  logic           flag_r;
  logic           flag_nxt;
  logic           enable_r;
  logic [7:0]     rdata_r;
  logic [7:0]     rdata_nxt;
  logic           cmp_latch_r;
  logic           cmp_latch_nxt;
  logic           match_seen_r;
  special_state_t se_state_r;
  special_state_t se_state_nxt;
  pin_drive_t     pins_r;
  pin_drive_t     pins_nxt;
  logic [9:0]     duty_r;
  logic           pin_meta_r;
  logic           pin_sync_r;
  logic           pin_prev_r;

  wire wr_ctrl    = wr_i && addr_i == CTRL_ADDR;
  wire wr_cap_lo  = wr_i && addr_i == CAP_LOW_ADDR;
  wire wr_cap_hi  = wr_i && addr_i == CAP_HIGH_ADDR;
  wire wr_flags   = wr_i && addr_i == IRQ_FLAGS_ADDR;
  wire wr_enable  = wr_i && addr_i == IRQ_ENABLE_ADDR;
  wire ctrl_clear = wr_ctrl && wdata_i[3:0] == MODE_OFF;

  wire [3:0] mode    = ctrl_r.mode;
  wire       ac_low  = mode[1];
  wire       bd_low  = mode[0];
  wire       cap_sel = is_capture(mode);
  wire       special = mode == MODE_CMP_SPECIAL;

  // ---------------------------------------------------------------
  // Capture path
  // ---------------------------------------------------------------
  // The pin is read back from the pad, so a port write that moves an
  // output-configured pin shows up here as an ordinary edge.
  wire pin_rise = pin_sync_r && !pin_prev_r;
  wire pin_fall = !pin_sync_r && pin_prev_r;
  logic cap_fire;

  capture_prescaler u_prescaler (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .mode_i    (mode),
    .rise_i    (pin_rise),
    .fall_i    (pin_fall),
    .fire_o    (cap_fire)
  );

  // Capture beats a software write to the pair in the same cycle
  always_comb begin
    cap_nxt = cap_r;
    if (wr_cap_lo) begin
      cap_nxt[7:0] = wdata_i;
    end
    if (wr_cap_hi) begin
      cap_nxt[15:8] = wdata_i;
    end
    if (cap_fire && cap_sel) begin
      cap_nxt = timer_one_count_i;
    end
  end

  // ---------------------------------------------------------------
  // Compare path
  // ---------------------------------------------------------------
  // Matching on the whole pair, one event per match episode; the count
  // stays equal for a full timer period at slow timer clocks.
  wire cmp_match   = is_compare(mode) &&
                     timer_one_count_i == cap_r;
  wire match_event = cmp_match && !match_seen_r;

  always_comb begin
    cmp_latch_nxt = cmp_latch_r;
    if (ctrl_clear || mode == MODE_OFF) begin
      cmp_latch_nxt = 1'b0;
    end else if (match_event) begin
      case (mode)
        MODE_CMP_TOGGLE: cmp_latch_nxt = !cmp_latch_r;
        MODE_CMP_SET:    cmp_latch_nxt = 1'b1;
        MODE_CMP_CLEAR:  cmp_latch_nxt = 1'b0;
        default:         cmp_latch_nxt = cmp_latch_r;
      endcase
    end
  end

  // Set wins over a software clear arriving in the same cycle
  wire flag_set = (cap_fire && cap_sel) || match_event;
  assign flag_nxt = flag_set ||
                    (wr_flags ? wdata_i[MODULE_IRQ_BIT] : flag_r);

  // ---------------------------------------------------------------
  // Special event trigger
  // ---------------------------------------------------------------
  // Pulses are gated by the enable so a frozen match cannot stretch them
  assign special_event_o   = ce_i && match_event && special;
  assign adc_start_o       = special_event_o && adc_enabled_i;
  assign timer_one_reset_o = ce_i && se_state_r == SE_WAIT && special &&
                             cmp_match && timer_one_tick_i;

  always_comb begin
    se_state_nxt = se_state_r;
    case (se_state_r)
      SE_IDLE: begin
        if (special_event_o) begin
          se_state_nxt = SE_WAIT;
        end
      end
      SE_WAIT: begin
        // A moved compare value cancels the pending timer reset
        if (!cmp_match || !special || timer_one_tick_i) begin
          se_state_nxt = SE_IDLE;
        end
      end
      default: se_state_nxt = SE_IDLE;
    endcase
    if (ctrl_clear) begin
      se_state_nxt = SE_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // Output steering
  // ---------------------------------------------------------------
  wire mod_a = pwm_primary_i ^ ac_low;
  wire mod_b = pwm_primary_i ^ bd_low;
  wire mod_d = pwm_primary_i ^ bd_low;
  wire cmp_b = pwm_complement_i ^ bd_low;

  always_comb begin
    pins_nxt = PINS_IDLE;
    if (!is_pwm(mode)) begin
      if (drives_pin(mode)) begin
        pins_nxt.drive_n[0] = 1'b0;
        pins_nxt.level[0]   = cmp_latch_r;
      end
    end else begin
      case (ctrl_r.steer)
        STEER_SINGLE: begin
          pins_nxt.drive_n = 4'he;
          pins_nxt.level   = {3'h0, mod_a};
        end
        STEER_FWD: begin
          pins_nxt.drive_n = 4'h0;
          pins_nxt.level   = {mod_d, ac_low, bd_low, !ac_low};
        end
        STEER_HALF: begin
          pins_nxt.drive_n = 4'hc;
          pins_nxt.level   = {2'h0, cmp_b, mod_a};
        end
        STEER_REV: begin
          pins_nxt.drive_n = 4'h0;
          pins_nxt.level   = {bd_low, !ac_low, mod_b, ac_low};
        end
        default: pins_nxt = PINS_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb begin
    rdata_nxt = READ_ZERO;
    if (rd_i) begin
      case (addr_i)
        CTRL_ADDR:       rdata_nxt = ctrl_r;
        CAP_LOW_ADDR:    rdata_nxt = cap_r[7:0];
        CAP_HIGH_ADDR:   rdata_nxt = cap_r[15:8];
        IRQ_FLAGS_ADDR:  rdata_nxt[MODULE_IRQ_BIT] = flag_r;
        IRQ_ENABLE_ADDR: rdata_nxt[MODULE_IRQ_BIT] = enable_r;
        default:         rdata_nxt = READ_ZERO;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
      pin_prev_r <= 1'b0;
    end else if (ce_i) begin
      pin_meta_r <= capture_pin_i;
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_r       <= CTRL_RESET;
      cap_r        <= CAP_RESET;
      flag_r       <= FLAG_RESET;
      enable_r     <= ENABLE_RESET;
      rdata_r      <= READ_ZERO;
      cmp_latch_r  <= 1'b0;
      match_seen_r <= 1'b0;
      se_state_r   <= SE_IDLE;
    end else if (ce_i) begin
      if (wr_ctrl) begin
        ctrl_r <= wdata_i;
      end
      if (wr_enable) begin
        enable_r <= wdata_i[MODULE_IRQ_BIT];
      end
      cap_r        <= cap_nxt;
      flag_r       <= flag_nxt;
      rdata_r      <= rdata_nxt;
      cmp_latch_r  <= cmp_latch_nxt;
      match_seen_r <= cmp_match;
      se_state_r   <= se_state_nxt;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pins_r <= PINS_IDLE;
      duty_r <= 10'h000;
    end else if (ce_i) begin
      pins_r <= pins_nxt;
      duty_r <= is_pwm(mode) ? {cap_r[7:0], ctrl_r.duty} : 10'h000;
    end
  end

  assign rdata_o             = rdata_r;
  assign pins_o              = pins_r;
  assign duty_value_o        = duty_r;
  assign timer_two_base_o    = is_pwm(mode);
  assign module_irq_flag_o   = flag_r;
  assign module_irq_enable_o = enable_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_capture_load: assert property (
    ce_i && cap_fire && cap_sel |=> cap_r == $past(timer_one_count_i))
    else $error("capture pair does not hold the timer count");

  a_flag_set: assert property (
    ce_i && flag_set |=> flag_r)
    else $error("capture or match did not set the flag");

  a_flag_sticky: assert property (
    flag_r && !(ce_i && wr_flags) |=> flag_r)
    else $error("flag cleared without a software write");

  a_clear_latch: assert property (
    ce_i && ctrl_clear |=> !cmp_latch_r && ctrl_r.mode == MODE_OFF)
    else $error("control clear left the compare latch high");

  a_toggle_match: assert property (
    ce_i && match_event && mode == MODE_CMP_TOGGLE && !wr_ctrl
    |=> cmp_latch_r != $past(cmp_latch_r))
    else $error("toggle mode did not toggle on match");

  a_set_clear: assert property (
    ce_i && match_event && !wr_ctrl &&
    (mode == MODE_CMP_SET || mode == MODE_CMP_CLEAR)
    |=> cmp_latch_r == ($past(mode) == MODE_CMP_SET))
    else $error("set or clear mode drove the wrong level");

  a_pin_release: assert property (
    !is_pwm(mode) && !drives_pin(mode) |-> pins_nxt == PINS_IDLE)
    else $error("pin driven in a mode that leaves it alone");

  a_port_return: assert property (
    !is_pwm(mode) |-> pins_nxt.drive_n[3:1] == 3'h7)
    else $error("outputs B to D not returned to port");

  a_single_steer: assert property (
    is_pwm(mode) && ctrl_r.steer == STEER_SINGLE
    |-> pins_nxt.drive_n == 4'he && pins_nxt.level[0] == mod_a)
    else $error("single output steering wrong");

  a_adc_start: assert property (
    adc_start_o |-> special_event_o && adc_enabled_i && special)
    else $error("converter started without an enabled special event");

  a_timer_reset: assert property (
    timer_one_reset_o |-> $past(special_event_o) ||
    se_state_r == SE_WAIT)
    else $error("timer reset without a pending special event");

endmodule // enhanced_capture_unit

// >>> capture_pin_source.sv
/*
  Model of the outside signal source that drives the capture pin.
  Assumes the unit samples the pin level on the rising edge of clock_i.
*/
`timescale 1ns/1ps

module capture_pin_source (
  input  wire logic clock_i,
  output logic      pin_o
);
  initial pin_o = 1'b0;

  // Each level stands 6 cycles, above the 3 that edge detection needs
  task automatic drive(input logic lvl);
    @(posedge clock_i) pin_o <= lvl;
    repeat (5) @(posedge clock_i);
  endtask

  task automatic pulse();
    drive(1'b1);
    drive(1'b0);
  endtask
endmodule // capture_pin_source

// >>> enhanced_capture_unit_tb_top.sv
/*
  Self-checking bench for the capture/compare/PWM mode control unit.
  Assumes the register port of ecap_pkg and a synchronous timer count.
*/
`timescale 1ns/1ps

module enhanced_capture_unit_tb_top;
  import ecap_pkg::*;

  typedef struct {
    logic [7:0] ctrl;
    logic [7:0] pins;
  } row_t;

  logic             clock_i = 1'b0;
  logic             reset_n_i = 1'b0;
  logic             ce_i = 1'b1;
  logic [2:0]       addr_i = 3'h0;
  logic [7:0]       wdata_i = 8'h00;
  logic             wr_i = 1'b0;
  logic             rd_i = 1'b0;
  logic [7:0]       rdata_o;
  logic             pin;
  logic [15:0]      tcount = 16'h0000;
  logic             pwm_p = 1'b1;
  logic             pwm_c = 1'b0;
  logic             tick = 1'b0;
  logic             adc_en = 1'b1;
  pin_drive_t       pins_o;
  logic [9:0]       duty_value_o;
  logic             timer_two_base_o;
  logic             flag;
  logic             irq_en;
  logic             se;
  logic             adc_start;
  logic             t1_rst;
  int               n_errors = 0;
  int               checks_done = 0;
  int               n_se = 0;
  int               n_adc = 0;
  int               n_rst = 0;
  // Pins seen as {driven levels, drive_n}; primary 1, complement 0
  row_t rows [11] = '{
    '{8'h0c, 8'h1e}, '{8'h1d, 8'h1e},
    '{8'h4c, 8'h90}, '{8'h6f, 8'h60},
    '{8'h8c, 8'h1c}, '{8'hae, 8'h0c},
    '{8'hcc, 8'h60}, '{8'hfd, 8'hc0},
    '{8'hc5, 8'h0f}, '{8'h8a, 8'h0f}, '{8'h40, 8'h0f}
  };

  always #20 clock_i = ~clock_i;

  capture_pin_source u_src (.clock_i(clock_i), .pin_o(pin));

  enhanced_capture_unit u_dut (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .capture_pin_i(pin),
    .timer_one_count_i(tcount), .timer_one_tick_i(tick),
    .adc_enabled_i(adc_en), .pwm_primary_i(pwm_p),
    .pwm_complement_i(pwm_c), .pins_o(pins_o),
    .duty_value_o(duty_value_o), .timer_two_base_o(timer_two_base_o),
    .module_irq_flag_o(flag), .module_irq_enable_o(irq_en),
    .special_event_o(se), .adc_start_o(adc_start),
    .timer_one_reset_o(t1_rst)
  );

  // Pulses last one cycle, so they are counted rather than sampled
  always @(posedge clock_i) begin
    if (se === 1'b1) n_se++;
    if (adc_start === 1'b1) n_adc++;
    if (t1_rst === 1'b1) n_rst++;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_i) begin
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
    end
    @(posedge clock_i) wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clock_i) begin
      addr_i <= a;
      rd_i <= 1'b1;
    end
    @(posedge clock_i) rd_i <= 1'b0;
    #1 check(rdata_o, exp);
  endtask

  task automatic cap_run(input logic [7:0] m, input int n, input logic e);
    wr(CTRL_ADDR, 8'h00);
    wr(CTRL_ADDR, m);
    wr(IRQ_FLAGS_ADDR, 8'h00);
    repeat (n) u_src.pulse();
    #1 check(flag, e);
  endtask

  task automatic cmp_hit();
    @(posedge clock_i) tcount <= 16'h0000;
    repeat (2) @(posedge clock_i);
    tcount <= 16'h1234;
    repeat (3) @(posedge clock_i);
    #1;
  endtask

  task automatic tick_once();
    @(posedge clock_i) tick <= 1'b1;
    @(posedge clock_i) tick <= 1'b0;
    repeat (2) @(posedge clock_i);
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clock_i);
    n_errors++;
    wrap_up();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clock_i);
    reset_n_i <= 1'b1;
    wr(CAP_LOW_ADDR, 8'ha5);
    foreach (rows[i]) begin
      wr(CTRL_ADDR, rows[i].ctrl);
      repeat (2) @(posedge clock_i);
      #1 check({pins_o.level & ~pins_o.drive_n, pins_o.drive_n},
               rows[i].pins);
      check(duty_value_o, (rows[i].ctrl[3:2] == 2'h3) ?
            {8'ha5, rows[i].ctrl[5:4]} : 10'h000);
      check(timer_two_base_o, rows[i].ctrl[3:2] == 2'h3);
      rd(CTRL_ADDR, rows[i].ctrl);
    end
    // Half bridge with the waveform low and its complement high
    wr(CTRL_ADDR, 8'h8c);
    pwm_p <= 1'b0;
    pwm_c <= 1'b1;
    repeat (2) @(posedge clock_i);
    #1 check({pins_o.level & ~pins_o.drive_n, pins_o.drive_n},
             8'h2c);
    pwm_p <= 1'b1;
    pwm_c <= 1'b0;
    // Capture, overwrite and sticky flag
    cap_run(8'h05, 0, 1'b0);
    tcount <= 16'h1a2b;
    u_src.pulse();
    check(flag, 1'b1);
    rd(CAP_LOW_ADDR, 8'h2b);
    rd(CAP_HIGH_ADDR, 8'h1a);
    tcount <= 16'h3c4d;
    u_src.pulse();
    rd(CAP_LOW_ADDR, 8'h4d);
    rd(CAP_HIGH_ADDR, 8'h3c);
    repeat (30) @(posedge clock_i);
    rd(IRQ_FLAGS_ADDR, 8'h20);
    wr(IRQ_FLAGS_ADDR, 8'h00);
    #1 check(flag, 1'b0);
    cap_run(8'h04, 0, 1'b0);
    u_src.drive(1'b1);
    check(flag, 1'b0);
    u_src.drive(1'b0);
    check(flag, 1'b1);
    // Prescaler counts and its clearing when off
    cap_run(8'h06, 2, 1'b0);
    cap_run(8'h06, 3, 1'b0);
    u_src.pulse();
    check(flag, 1'b1);
    cap_run(8'h07, 15, 1'b0);
    u_src.pulse();
    check(flag, 1'b1);
    // Compare pin actions
    wr(CAP_LOW_ADDR, 8'h34);
    wr(CAP_HIGH_ADDR, 8'h12);
    cap_run(8'h08, 0, 1'b0);
    cmp_hit();
    check({pins_o.level[0], pins_o.drive_n[0], flag}, 3'b101);
    wr(CTRL_ADDR, 8'h09);
    cmp_hit();
    check({pins_o.level[0], pins_o.drive_n[0]}, 2'b00);
    wr(CTRL_ADDR, 8'h02);
    cmp_hit();
    check({pins_o.level[0], pins_o.drive_n[0]}, 2'b10);
    // Move off the match so re-entering compare raises no fresh event
    tcount <= 16'h0000;
    wr(CTRL_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'h02);
    repeat (2) @(posedge clock_i);
    #1 check({pins_o.level[0], pins_o.drive_n[0]}, 2'b00);
    cap_run(8'h0a, 0, 1'b0);
    cmp_hit();
    check({pins_o.drive_n[0], flag}, 2'b11);
    // Special event: trigger at once, timer reset on the next tick
    tcount <= 16'h0000;
    cap_run(8'h0b, 0, 1'b0);
    cmp_hit();
    check({n_se[3:0], n_adc[3:0], n_rst[3:0]}, 12'h110);
    tick_once();
    check({n_se[3:0], n_adc[3:0], n_rst[3:0], flag}, 13'h0223);
    adc_en <= 1'b0;
    cmp_hit();
    tcount <= 16'h0000;
    tick_once();
    check({n_se[3:0], n_adc[3:0], n_rst[3:0]}, 12'h211);
    // Register port corners
    wr(IRQ_ENABLE_ADDR, 8'hff);
    rd(IRQ_ENABLE_ADDR, 8'h20);
    check(irq_en, 1'b1);
    wr(3'h5, 8'hff);
    rd(3'h5, READ_ZERO);
    @(posedge clock_i) ce_i <= 1'b0;
    wr(CTRL_ADDR, 8'h0c);
    @(posedge clock_i) ce_i <= 1'b1;
    rd(CTRL_ADDR, 8'h0b);
    // Reset in mid-run
    @(posedge clock_i) reset_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    reset_n_i <= 1'b1;
    rd(CTRL_ADDR, CTRL_RESET);
    rd(IRQ_FLAGS_ADDR, 8'h00);
    rd(IRQ_ENABLE_ADDR, 8'h00);
    rd(CAP_LOW_ADDR, CAP_RESET[7:0]);
    check({pins_o.level & ~pins_o.drive_n, pins_o.drive_n}, 8'h0f);
    wrap_up();
  end
endmodule // enhanced_capture_unit_tb_top
